/* bench/diag_assertions.sv */
// Checker for the diagnostic flag and channel enable block
`timescale 1ns/1ps
module diag_checker
(
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  input wire logic [7:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire diag_pkg::err_vec_t    errEnable,
  input wire diag_pkg::err_vec_t    monitorCond,
  input wire logic                  serialErrRecorded,
  input wire logic                  coefficient_filter_mode,
  input wire logic                  calibrationMode,
  input wire logic                  convActive,
  input wire logic                  convDone,
  input wire diag_pkg::repeat_arr_t repeatCount,
  input wire logic [3:0]            activeChannel,
  input wire logic                  channelSwitch,
  input wire logic                  filterReset,
  input wire logic                  errorPending
);
  logic [15:0] gatedCond;
  // Bits 2..0 have other sources, so only the plain monitors count here
  assign gatedCond = monitorCond & errEnable & 16'h3ff8;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence seqReq;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence seqChanWr;
    avs_write && !avs_waitrequest && avs_address == 8'h78;
  endsequence
  sequence seqSingle;
    coefficient_filter_mode || calibrationMode;
  endsequence
  chk_wait_answer: assert property
    (seqReq |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("wait cycle count wrong");
  chk_rest_high: assert property
    (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest &&
    avs_address != 8'h74 && avs_address != 8'h78 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_filter_pulse: assert property
    (seqChanWr |=> filterReset ##1 !filterReset)
    else $error("filter reset pulse missing");
  chk_filter_cause: assert property
    (filterReset |-> $past(avs_write && !avs_waitrequest &&
     avs_address == 8'h78))
    else $error("filter reset without channel write");
  chk_flag_raise: assert property (|gatedCond |-> ##2 errorPending)
    else $error("enabled monitor raised no flag");
  chk_init_raise: assert property
    (monitorCond.deviceInitFail |-> ##2 errorPending)
    else $error("init failure raised no flag");
  chk_serial_raise: assert property
    (serialErrRecorded && errEnable.serialInterfaceFlag |-> ##2 errorPending)
    else $error("serial error raised no flag");
  chk_pend_release: assert property
    ($fell(errorPending) |-> $past(avs_write, 2))
    else $error("flags cleared without a write");
  chk_switch_cause: assert property
    (channelSwitch |-> $past(convDone) && $changed(activeChannel))
    else $error("channel switch without conversion end");
  chk_single_mode: assert property
    (seqSingle[*2] |-> !channelSwitch)
    else $error("channel switch in single channel mode");
endmodule : diag_checker
bind diag_error_flags_and_channel_enable diag_checker chk
(
  .core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .errEnable, .monitorCond, .serialErrRecorded, .coefficient_filter_mode,
  .calibrationMode, .convActive, .convDone, .repeatCount, .activeChannel,
  .channelSwitch, .filterReset, .errorPending
);

/* bench/diag_error_flags_and_channel_enable_test.sv */
// Testbench for the diagnostic flag and channel enable block
`timescale 1ns/1ps
module diag_error_flags_and_channel_enable_test;
  logic                  core_clk;
  logic                  reset_n;
  logic [7:0]            avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  diag_pkg::err_vec_t    errEnable;
  diag_pkg::err_vec_t    monitorCond;
  logic                  serialErrRecorded;
  logic                  coefficient_filter_mode;
  logic                  calibrationMode;
  logic                  convActive;
  logic                  convDone;
  diag_pkg::repeat_arr_t repeatCount;
  logic [3:0]            activeChannel;
  logic                  channelSwitch;
  logic                  filterReset;
  logic                  errorPending;
  logic                  busHung;
  int                    n_mismatch;
  int                    total_checks;
  diag_error_flags_and_channel_enable dut
  (
    .core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .errEnable, .monitorCond, .serialErrRecorded, .coefficient_filter_mode,
    .calibrationMode, .convActive, .convDone, .repeatCount, .activeChannel,
    .channelSwitch, .filterReset, .errorPending
  );
  host_model host
  (
    .core_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .busHung
  );
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ********
  // Tasks
  // ********
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    host.access(1'b0, a, 16'h0, 4'h3);
    check(host.readData, exp);
  endtask : rdChk
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] be);
    host.access(1'b1, a, d, be);
  endtask : wr
  task automatic doReset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : doReset
  task automatic raise(input logic [15:0] c, input logic [15:0] en,
                       input logic s, input logic coef);
    @(posedge core_clk);
    monitorCond             <= diag_pkg::err_vec_t'(c);
    errEnable               <= diag_pkg::err_vec_t'(en);
    serialErrRecorded       <= s;
    coefficient_filter_mode <= coef;
    repeat (3) @(posedge core_clk);
    monitorCond       <= '0;
    serialErrRecorded <= 1'b0;
  endtask : raise
  task automatic convChk(input logic [3:0] ch, input logic sw);
    @(posedge core_clk);
    convDone <= 1'b1;
    @(posedge core_clk);
    convDone <= 1'b0;
    #1;
    check({28'h0, activeChannel}, {28'h0, ch});
    check({31'h0, channelSwitch}, {31'h0, sw});
  endtask : convChk
  always @(posedge busHung)
  begin
    n_mismatch++;
    test_done();
  end
  // ********
  // Scenarios
  // ********
  initial
  begin
    reset_n = 1'b0;
    errEnable = '0;
    monitorCond = '0;
    serialErrRecorded = 1'b0;
    coefficient_filter_mode = 1'b0;
    calibrationMode = 1'b0;
    convActive = 1'b0;
    convDone = 1'b0;
    repeatCount = '0;
    n_mismatch = 0;
    total_checks = 0;
    doReset();
    rdChk(8'h74, 32'h0);
    rdChk(8'h78, 32'h1);
    rdChk(8'h70, 32'h0);
    wr(8'h70, 16'hffff, 4'h3);
    rdChk(8'h78, 32'h1);
    wr(8'h78, 16'ha5c3, 4'h3);
    #1 check({31'h0, filterReset}, 32'h1);
    wr(8'h78, 16'h5a3c, 4'h1);
    rdChk(8'h78, 32'ha53c);
    $display("test registers done");
    // Bit 1 comes only from the internal checksum, tested further down
    for (int b = 0; b < 14; b++)
    begin
      if (b == 1)
        continue;
      raise(b == 2 ? 16'h0 : 16'h1 << b, 16'h0, b == 2, b == 0);
      rdChk(8'h74, 32'h0);
      raise(b == 2 ? 16'h0 : 16'h1 << b, 16'h3ffd, b == 2, b == 0);
      rdChk(8'h74, 32'h1 << b);
      wr(8'h74, 16'h1 << b, 4'h3);
      rdChk(8'h74, 32'h0);
    end
    errEnable   <= diag_pkg::err_vec_t'(16'h2000);
    monitorCond <= diag_pkg::err_vec_t'(16'h2000);
    wr(8'h74, 16'h2000, 4'h3);
    rdChk(8'h74, 32'h2000);
    monitorCond <= '0;
    wr(8'h74, 16'h0000, 4'h3);
    wr(8'h74, 16'h2000, 4'h1);
    rdChk(8'h74, 32'h2000);
    wr(8'h74, 16'h2000, 4'h3);
    rdChk(8'h74, 32'h0);
    raise(16'hc000, 16'h0, 1'b0, 1'b0);
    wr(8'h74, 16'hffff, 4'h3);
    rdChk(8'h74, 32'h8000);
    doReset();
    rdChk(8'h74, 32'h0);
    $display("test flags done");
    raise(16'h0, 16'h0002, 1'b0, 1'b0);
    wr(8'h78, 16'h0003, 4'h3);
    for (int i = 0; i < 9000 && errorPending !== 1'b1; i++)
      @(posedge core_clk);
    // A checksum that never trips ends the run as a failure
    if (errorPending !== 1'b1)
    begin
      n_mismatch++;
      test_done();
    end
    rdChk(8'h74, 32'h2);
    errEnable <= '0;
    wr(8'h74, 16'h0002, 4'h3);
    rdChk(8'h74, 32'h0);
    $display("test checksum done");
    wr(8'h78, 16'h0005, 4'h3);
    convActive <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check({28'h0, activeChannel}, 32'h0);
    convChk(4'h2, 1'b1);
    convChk(4'h0, 1'b1);
    repeatCount[2] <= 8'h02;
    convChk(4'h2, 1'b1);
    convChk(4'h2, 1'b0);
    convChk(4'h0, 1'b1);
    convChk(4'h2, 1'b1);
    wr(8'h78, 16'h0005, 4'h3);
    repeat (2) @(posedge core_clk);
    #1 check({28'h0, activeChannel}, 32'h0);
    wr(8'h78, 16'h0008, 4'h3);
    convChk(4'h3, 1'b0);
    convChk(4'h3, 1'b0);
    wr(8'h78, 16'h0000, 4'h3);
    convChk(4'h0, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      {calibrationMode, coefficient_filter_mode} <= 2'h1 << m;
      wr(8'h78, 16'h0005, 4'h3);
      convChk(4'h0, 1'b0);
      convChk(4'h0, 1'b0);
    end
    $display("test sequencer done");
    if (errorPending !== 1'b1 && errorPending !== 1'b0)
      n_mismatch++;
    test_done();
  end
endmodule : diag_error_flags_and_channel_enable_test

/* bench/host_model.sv */
// Host software model driving the register bus as master
`timescale 1ns/1ps
module host_model
(
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  output logic             busHung
);
  logic [31:0] readData;
  initial
  begin
    avs_address    = 8'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
    busHung        = 1'b0;
    readData       = 32'h0;
  end
  // ********
  // Access
  // ********
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d, input logic [3:0] be);
    int n = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0, d};
    avs_byteenable <= be;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest && n < 20);
    readData = avs_readdata;
    busHung   <= busHung | avs_waitrequest;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Released lines flip so a stale value is never taken as live
    avs_address   <= ~a;
    avs_writedata <= ~{16'h0, d};
  endtask : access
endmodule : host_model

/* core/channel_picker.sv */
// Finds the lowest enabled channel and the next one above the current
`timescale 1ns/1ps
module channel_picker
(
  input  wire logic [15:0] mask,
  input  wire logic [3:0]  current,
  output logic      [3:0]  lowest,
  output logic      [3:0]  next
);

  // ****************************************************************
  // Priority search
  // ****************************************************************
  logic       foundAbove;
  logic [3:0] above;

  always_comb
  begin
    lowest     = 4'h0;
    above      = 4'h0;
    foundAbove = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (mask[i])
        lowest = 4'(i);
      if (mask[i] && (4'(i) > current))
      begin
        above      = 4'(i);
        foundAbove = 1'b1;
      end
    end
    // Ascending walk, wrapping to the lowest after the highest
    next = foundAbove ? above : lowest;
  end

endmodule : channel_picker

/* core/diag_error_flags_and_channel_enable.sv */
// Diagnostic error flags, channel enable register and channel sequencer
//
// Operation
// - Enabled monitor detecting its error sets its flag, which stays set.
// - Write one clears a flag once its condition is gone; zero is ignored.
// - A monitor raises its flag only when its error-enable bit is set; bit 15 init failure has no enable bit and always reports.
// - Bit 15 init failure flag is read-only and never cleared by writes.
// - Error status register is zero after reset.
// - Separate low-output flags for digital and analog regulators.
// - Four compliance flags, one per excitation current output.
// - Flag for reference differential voltage too small.
// - Range flags for positive input, negative input and reference input.
// - Flag for conversion result over or under range.
// - Flag mirrors a serial interface error when reporting is enabled.
// - Flags for register map checksum and coefficient checksum failures.
// - Channel enable register reads 0x0001 after reset.
// - Sixteen read/write bits, bit n enables channel n.
// - One enabled channel is converted repeatedly without sequencing.
// - Several enabled channels are visited lowest to highest.
// - A selected channel gets its setup and programmed conversion count.
// - Filter-coefficient mode and calibrations use one channel only.
// - An all-zero enable register selects channel 0.
// - Channel enable writes reset filter, control logic and sequencer.
// - Serial error flag mirrors interface status, only when enabled.
// - Checksum snapshot taken when enabled, rechecked periodically.
// - Repeat count zero gives a single conversion before moving on.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module diag_error_flags_and_channel_enable
(
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire diag_pkg::err_vec_t      errEnable,
  input  wire diag_pkg::err_vec_t      monitorCond,
  input  wire logic                    serialErrRecorded,
  input  wire logic                    coefficient_filter_mode,
  input  wire logic                    calibrationMode,
  input  wire logic                    convActive,
  input  wire logic                    convDone,
  input  wire diag_pkg::repeat_arr_t   repeatCount,
  output logic      [3:0]              activeChannel,
  output logic                         channelSwitch,
  output logic                         filterReset,
  output logic                         errorPending
);

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic        waitReq_ff;
  logic [31:0] readData_ff;
  logic        busReq;
  logic        doWrite;
  logic        hitErr;
  logic        hitChan;
  logic [15:0] laneMask;
  logic [15:0] readMux;
  logic [15:0] flags;
  logic [15:0] chanEnable_ff;

  assign busReq   = avs_read | avs_write;
  // Access completes on the edge where waitrequest is seen low
  assign doWrite  = avs_write & ~waitReq_ff;
  assign hitErr   = (avs_address == diag_pkg::ERR_STATUS_ADDR);
  assign hitChan  = (avs_address == diag_pkg::CHAN_ENABLE_ADDR);
  assign laneMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb
  begin
    readMux = 16'h0000;
    if (hitErr)
      readMux = flags & diag_pkg::ERR_LIVE_MASK;
    else if (hitChan)
      readMux = chanEnable_ff;
  end

  // One wait cycle per access keeps the decode off the critical path
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      waitReq_ff <= 1'b1;
    else
      waitReq_ff <= ~(busReq & waitReq_ff);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      readData_ff <= 32'h0000_0000;
    else if (avs_read && waitReq_ff)
      readData_ff <= {16'h0000, readMux};
  end

  assign avs_readdata    = readData_ff;
  assign avs_waitrequest = waitReq_ff;

  // ****************************************************************
  // Channel enable register
  // ****************************************************************
  logic        chanWrite;
  logic [15:0] nxt_chanEnable;

  assign chanWrite      = doWrite & hitChan & (|avs_byteenable[1:0]);
  assign nxt_chanEnable = (chanEnable_ff & ~laneMask) |
                          (avs_writedata[15:0] & laneMask);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      chanEnable_ff <= diag_pkg::CHAN_ENABLE_RESET;
    else if (chanWrite)
      chanEnable_ff <= nxt_chanEnable;
  end

  // ****************************************************************
  // Register map checksum
  // ****************************************************************
  logic [15:0] mapSum;
  logic [15:0] refSum_ff;
  logic        crcArmed_ff;
  logic        crcMismatch_ff;
  logic [11:0] crcCnt_ff;

  // Folds chanEnable_ff and errEnable; only a write that changes the XOR of the two enable bytes shows up
  assign mapSum = chanEnable_ff ^ errEnable ^ {chanEnable_ff[7:0],
                  chanEnable_ff[15:8]};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crcArmed_ff <= 1'b0;
      refSum_ff   <= 16'h0000;
    end
    else if (!errEnable.register_map_checksum_flag)
      crcArmed_ff <= 1'b0;
    else if (!crcArmed_ff)
    begin
      crcArmed_ff <= 1'b1;
      refSum_ff   <= mapSum;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      crcCnt_ff <= 12'h000;
    else if (!crcArmed_ff || crcCnt_ff == diag_pkg::CRC_CNT_LAST)
      crcCnt_ff <= 12'h000;
    else
      crcCnt_ff <= crcCnt_ff + 12'h001;
  end

  // Mismatch latches so it stays a live condition until the checksum is disarmed
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      crcMismatch_ff <= 1'b0;
    else if (!crcArmed_ff)
      crcMismatch_ff <= 1'b0;
    else if (crcCnt_ff == diag_pkg::CRC_CNT_LAST && mapSum != refSum_ff)
      crcMismatch_ff <= 1'b1;
  end

  // ****************************************************************
  // Error status flags
  // ****************************************************************
  diag_pkg::err_vec_t liveCond;
  diag_pkg::err_vec_t gateEn;
  logic [15:0]        setReq;
  logic [15:0]        clrReq;

  always_comb
  begin
    liveCond = monitorCond;
    liveCond.reserved = 1'b0;
    liveCond.serialInterfaceFlag = serialErrRecorded;
    liveCond.register_map_checksum_flag = crcMismatch_ff;
    // Coefficient check only exists in the coefficient filter mode
    liveCond.coefficientChecksumFlag =
      monitorCond.coefficientChecksumFlag & coefficient_filter_mode;
  end

  always_comb
  begin
    gateEn = errEnable;
    // Init failure has no enable bit; it always reports
    gateEn.deviceInitFail = 1'b1;
    gateEn.reserved       = 1'b0;
  end

  // Each field is its own monitor: regulators, four sources, reference,
  // three range monitors, conversion, serial and two checksums
  assign setReq = liveCond &
                  gateEn;

  // Bit 15 is left out of the clear mask in the bank
  assign clrReq = (doWrite && hitErr) ?
                  (avs_writedata[15:0] & laneMask) : 16'h0000;

  error_flag_bank u_flags
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .setReq   (setReq),
    .clrReq   (clrReq),
    .condLive (liveCond),
    .flags_ff (flags)
  );

  logic errorPending_ff;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      errorPending_ff <= 1'b0;
    else
      errorPending_ff <= |flags;
  end

  assign errorPending = errorPending_ff;

  // ****************************************************************
  // Channel sequencer
  // ****************************************************************
  diag_pkg::seq_state_t seqState_ff;
  logic [15:0]          effMask;
  logic [3:0]           lowestChan;
  logic [3:0]           nextChan;
  logic [3:0]           activeChan_ff;
  logic [3:0]           nxt_chan;
  logic [7:0]           repeatLeft_ff;
  logic                 singleMode;
  logic                 switch_ff;
  logic                 filterReset_ff;

  // No channel enabled falls back to channel 0
  assign effMask = (chanEnable_ff == 16'h0000) ?
                   diag_pkg::CHAN_FALLBACK : chanEnable_ff;
  // Filter-coefficient and calibration modes never step channels
  assign singleMode = coefficient_filter_mode | calibrationMode;

  channel_picker u_picker
  (
    .mask    (effMask),
    .current (activeChan_ff),
    .lowest  (lowestChan),
    .next    (nextChan)
  );

  // A lone enabled channel makes next equal current
  assign nxt_chan = singleMode ? lowestChan : nextChan;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      seqState_ff <= diag_pkg::SEQ_IDLE;
    else if (chanWrite || !convActive)
      seqState_ff <= diag_pkg::SEQ_IDLE;
    else
      seqState_ff <= diag_pkg::SEQ_RUN;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      activeChan_ff <= 4'h0;
    else if (seqState_ff == diag_pkg::SEQ_IDLE || chanWrite)
      activeChan_ff <= lowestChan;
    else if (convDone && (singleMode || repeatLeft_ff == 8'h00))
      activeChan_ff <= nxt_chan;
  end

  // Repeat value N gives N conversions; zero gives just one
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      repeatLeft_ff <= 8'h00;
    else
      case (seqState_ff)
        diag_pkg::SEQ_IDLE:
        begin
          if (repeatCount[lowestChan] == 8'h00)
            repeatLeft_ff <= 8'h00;
          else
            repeatLeft_ff <= repeatCount[lowestChan] - 8'h01;
        end
        diag_pkg::SEQ_RUN:
        begin
          if (convDone && repeatLeft_ff != 8'h00 && !singleMode)
            repeatLeft_ff <= repeatLeft_ff - 8'h01;
          else if (convDone && repeatCount[nxt_chan] == 8'h00)
            repeatLeft_ff <= 8'h00;
          else if (convDone)
            repeatLeft_ff <= repeatCount[nxt_chan] - 8'h01;
        end
        default:
          repeatLeft_ff <= 8'h00;
      endcase
  end

  // Pulse when a conversion end moves to a different channel's setup, not on a channel enable write
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      switch_ff <= 1'b0;
    else if (seqState_ff == diag_pkg::SEQ_RUN && convDone && !chanWrite &&
             (singleMode || repeatLeft_ff == 8'h00))
      switch_ff <= (nxt_chan != activeChan_ff);
    else
      switch_ff <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      filterReset_ff <= 1'b0;
    else
      filterReset_ff <= chanWrite;
  end

  assign activeChannel = activeChan_ff;
  assign channelSwitch = switch_ff;
  assign filterReset   = filterReset_ff;

endmodule : diag_error_flags_and_channel_enable

/* core/diag_pkg.sv */
// Package: register map, flag layout, sequencer types and timing constants
package diag_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam int          REG_W             = 16;
  localparam int          NUM_CHAN          = 16;
  localparam int          CHAN_W            = 4;
  localparam int          REPEAT_W          = 8;
  localparam logic [7:0]  ERR_STATUS_ADDR   = 8'h74;
  localparam logic [7:0]  CHAN_ENABLE_ADDR  = 8'h78;
  localparam logic [15:0] ERR_STATUS_RESET  = 16'h0000;
  localparam logic [15:0] CHAN_ENABLE_RESET = 16'h0001;
  localparam logic [15:0] CHAN_FALLBACK     = 16'h0001;

  // ****************************************************************
  // Error flag positions
  // ****************************************************************
  localparam int BIT_DEVICE_INIT  = 15;
  localparam int BIT_RESERVED     = 14;
  localparam int BIT_DIG_REG_LOW  = 13;
  localparam int BIT_ANA_REG_LOW  = 12;
  localparam int BIT_EXC_SRC0     = 8;
  localparam int BIT_REF_SMALL    = 7;
  localparam int BIT_REF_RANGE    = 6;
  localparam int BIT_NEG_RANGE    = 5;
  localparam int BIT_POS_RANGE    = 4;
  localparam int BIT_CONV_RANGE   = 3;
  localparam int BIT_SERIAL_ERR   = 2;
  localparam int BIT_MAP_CHECKSUM = 1;
  localparam int BIT_COEF_CHECK   = 0;
  // Bits that a write of one may clear
  localparam logic [15:0] ERR_CLEARABLE_MASK = 16'h3fff;
  // Bits that a monitor may ever raise
  localparam logic [15:0] ERR_LIVE_MASK      = 16'hbfff;

  typedef struct packed {
    logic       deviceInitFail;
    logic       reserved;
    logic       digital_regulator_low_flag;
    logic       analog_regulator_low_flag;
    logic [3:0] excitationCompliance;
    logic       reference_too_small_flag;
    logic       reference_input_range_flag;
    logic       negative_input_range_flag;
    logic       positive_input_range_flag;
    logic       conversion_overrange_flag;
    logic       serialInterfaceFlag;
    logic       register_map_checksum_flag;
    logic       coefficientChecksumFlag;
  } err_vec_t;

  typedef logic [NUM_CHAN-1:0][REPEAT_W-1:0] repeat_arr_t;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ     = 40;
  localparam int CRC_PERIOD_US    = 100;
  localparam int CRC_PERIOD_CYC   = CRC_PERIOD_US * CLK_FREQ_MHZ;
  localparam int CRC_CNT_W        = 12;
  localparam logic [11:0] CRC_CNT_LAST = 12'(CRC_PERIOD_CYC - 1);

endpackage : diag_pkg

/* core/error_flag_bank.sv */
// Sticky write-one-to-clear flag bank, one cell per status bit
`timescale 1ns/1ps
module error_flag_bank
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] setReq,
  input  wire logic [15:0] clrReq,
  input  wire logic [15:0] condLive,
  output logic      [15:0] flags_ff
);

  // ****************************************************************
  // Flag cells
  // ****************************************************************
  logic [15:0] nxt_flags;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_flag
      logic clrOk;
      // A clear is honoured only once the condition has gone away
      assign clrOk = clrReq[gi] & ~condLive[gi] &
                     diag_pkg::ERR_CLEARABLE_MASK[gi];
      // Set wins over a clear in the same cycle
      assign nxt_flags[gi] = (setReq[gi] & diag_pkg::ERR_LIVE_MASK[gi]) |
                             (flags_ff[gi] & ~clrOk);
    end
  endgenerate

  // One process owns the whole register so no bit has two drivers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_ff <= diag_pkg::ERR_STATUS_RESET;
    else
      flags_ff <= nxt_flags;
  end

endmodule : error_flag_bank
